/* core/eidp_pkg.sv */
package eidp_pkg;

    // ****************************************
    // identification page geometry
    // ****************************************
    localparam int PAGE_BYTES = 32;
    localparam int OFFSET_W   = 6;
    localparam int INDEX_W    = 5;
    localparam int DATA_W     = 8;

    // ****************************************
    // address byte and command decoding
    // ****************************************
    localparam logic [3:0] DEV_TYPE_ID   = 4'hb;
    localparam logic [3:0] DEV_TYPE_MAIN = 4'ha;
    localparam int         RW_BIT        = 0;
    localparam int         LOCK_ADDR_BIT = 2;
    localparam int         LOCK_DATA_BIT = 1;
    localparam int         TYPE_MSB      = 7;
    localparam int         TYPE_LSB      = 4;
    localparam int         CS_MSB        = 3;
    localparam int         CS_LSB        = 1;

    localparam logic [1:0] IDX_DEV     = 2'h0;
    localparam logic [1:0] IDX_ADDR_HI = 2'h1;
    localparam logic [1:0] IDX_ADDR_LO = 2'h2;
    localparam logic [1:0] IDX_DATA    = 2'h3;

    localparam logic [3:0] BIT_ZERO      = 4'h0;
    localparam logic [3:0] BIT_FIRST     = 4'h1;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // ****************************************
    // write buffer
    // ****************************************
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_WIDTH = INDEX_W + DATA_W;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_RX   = 5'h02,
        S_ACK  = 5'h04,
        S_TX   = 5'h08,
        S_MACK = 5'h10
    } eidp_state_t;

endpackage

/* core/eidp_fifo.sv */
`timescale 1ns/100ps
module eidp_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0]   FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_SLOT  = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == LAST_SLOT) ? '0 : p + 1'b1;
    endfunction

    assign in_ready  = (count != FULL_COUNT);
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= bump(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= bump(rd_ptr);
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

    // storage carries no reset; count guards every read
    always_ff @(posedge clk) begin
        if (push && !flush) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

/* core/eidp_top.sv */
// Behaviour
// - A separate 32-byte identification page is kept; once locked it is permanently read-only.
// - Page reads use dummy write, repeated start, read, with type code 1011b in the address byte.
// - The five lowest address bits give the page offset; bits five to fifteen are ignored except bit ten, which selects the lock command.
// - A page write plus one data byte is acked when unlocked and not acked when locked.
// - A start resets the command logic and discards a pending truncated command.
// - A stop ending an aborted or query-only command returns to standby with no programming.
// - The address byte is type code, three chip-select bits, then the read/write bit.
// - A read/write bit of one selects a read and zero selects a write.
// - A byte write with lock address bit ten and data bit one set locks the page for good.
// - Once locked, every data byte of a page write is not acknowledged.
`timescale 1ns/100ps
module eidp_top (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic clk_link,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic chip_select_bit_high,
    input  wire logic chip_select_bit_mid,
    input  wire logic chip_select_bit_low,
    output logic      id_page_locked,
    output logic      id_page_committed
);
    localparam int OW = eidp_pkg::OFFSET_W;
    localparam int IW = eidp_pkg::INDEX_W;
    localparam int DW = eidp_pkg::DATA_W;

    // ****************************************
    // link reset and pin synchronisers
    // ****************************************
    logic [1:0] rst_link_sync;
    logic       rst_link;
    logic       scl_meta, scl_s, scl_q;
    logic       sda_meta, sda_s, sda_q;
    logic [2:0] cs_meta, cs_s;

    assign rst_link = rst_link_sync[1];

    always_ff @(posedge clk_link or posedge reset) begin
        if (reset) begin
            rst_link_sync <= 2'h3;
        end else begin
            rst_link_sync <= {rst_link_sync[0], 1'b0};
        end
    end

    // idle bus reads high, so the scl and sda sync chains start high; the chip-select chain starts low
    always_ff @(posedge clk_link or posedge rst_link) begin
        if (rst_link) begin
            {scl_meta, scl_s, scl_q} <= 3'h7;
            {sda_meta, sda_s, sda_q} <= 3'h7;
            cs_meta                  <= 3'h0;
            cs_s                     <= 3'h0;
        end else begin
            scl_meta <= scl_in;
            scl_s    <= scl_meta;
            scl_q    <= scl_s;
            sda_meta <= sda_in;
            sda_s    <= sda_meta;
            sda_q    <= sda_s;
            cs_meta  <= {chip_select_bit_high, chip_select_bit_mid, chip_select_bit_low};
            cs_s     <= cs_meta;
        end
    end

    logic scl_rise, scl_fall, start_ev, stop_ev;
    assign scl_rise = scl_s && !scl_q;
    assign scl_fall = !scl_s && scl_q;
    assign start_ev = scl_s && scl_q && sda_q && !sda_s;
    assign stop_ev  = scl_s && scl_q && !sda_q && sda_s;

    // ****************************************
    // command state
    // ****************************************
    eidp_pkg::eidp_state_t state;
    logic [3:0]    bit_cnt;
    logic [1:0]    byte_idx;
    logic [DW-1:0] shreg;
    logic          reading;
    logic          mack;
    logic          lock_sel;
    logic [OW-1:0] ptr;
    logic          locked;
    logic          pend_lock;
    logic          pend_write;
    logic          committing;
    logic          commit_tgl;
    logic [DW-1:0] page [eidp_pkg::PAGE_BYTES];
    logic [DW-1:0] rd_byte;
    logic [OW-1:0] addr_lo_offset;
    logic [3:0]    dev_type;
    logic [2:0]    dev_cs;

    logic                          fifo_in_valid, fifo_in_ready;
    logic                          fifo_out_valid;
    logic [eidp_pkg::FIFO_WIDTH-1:0] fifo_out_data;
    logic                          eval, ack_ok, load_tx, push_acc;

    // page-local increment: the offset wraps inside the 32-byte page
    function automatic logic [OW-1:0] next_offset(input logic [OW-1:0] p);
        return {p[OW-1], p[IW-1:0] + 1'b1};
    endfunction

    assign rd_byte        = page[ptr[IW-1:0]];
    assign addr_lo_offset = shreg[OW-1:0];
    assign dev_type       = shreg[eidp_pkg::TYPE_MSB:eidp_pkg::TYPE_LSB];
    assign dev_cs         = shreg[eidp_pkg::CS_MSB:eidp_pkg::CS_LSB];
    assign eval           = (state == eidp_pkg::S_RX) && (bit_cnt == eidp_pkg::BITS_PER_BYTE)
                            && scl_fall;

    always_comb begin
        case (byte_idx)
            eidp_pkg::IDX_DEV:  ack_ok = (dev_type == eidp_pkg::DEV_TYPE_ID)
                                         && (dev_cs == cs_s);
            eidp_pkg::IDX_DATA: ack_ok = !locked && (lock_sel || fifo_in_ready);
            default:            ack_ok = 1'b1;
        endcase
    end

    assign fifo_in_valid = eval && (byte_idx == eidp_pkg::IDX_DATA) && !lock_sel && !locked;
    assign push_acc      = fifo_in_valid && fifo_in_ready;
    assign load_tx       = (state == eidp_pkg::S_ACK && scl_fall && sda_oe && reading
                            && byte_idx == eidp_pkg::IDX_DEV)
                        || (state == eidp_pkg::S_MACK && scl_fall && mack);

    // ****************************************
    // bit and byte sequencer
    // ****************************************
    always_ff @(posedge clk_link or posedge rst_link) begin
        if (rst_link) begin
            state    <= eidp_pkg::S_IDLE;
            bit_cnt  <= eidp_pkg::BIT_ZERO;
            byte_idx <= eidp_pkg::IDX_DEV;
            shreg    <= '0;
            reading  <= 1'b0;
            mack     <= 1'b0;
            sda_oe   <= 1'b0;
        end else if (start_ev) begin
            state    <= eidp_pkg::S_RX;
            bit_cnt  <= eidp_pkg::BIT_ZERO;
            byte_idx <= eidp_pkg::IDX_DEV;
            sda_oe   <= 1'b0;
        end else if (stop_ev) begin
            state  <= eidp_pkg::S_IDLE;
            sda_oe <= 1'b0;
        end else begin
            case (state)
                eidp_pkg::S_IDLE: begin
                    sda_oe <= 1'b0;
                end
                eidp_pkg::S_RX: begin
                    if (scl_rise && bit_cnt != eidp_pkg::BITS_PER_BYTE) begin
                        shreg   <= {shreg[DW-2:0], sda_s};
                        bit_cnt <= bit_cnt + 1'b1;
                    end else if (eval) begin
                        sda_oe <= ack_ok;
                        state  <= eidp_pkg::S_ACK;
                        if (byte_idx == eidp_pkg::IDX_DEV) begin
                            reading <= shreg[eidp_pkg::RW_BIT];
                        end
                    end
                end
                eidp_pkg::S_ACK: begin
                    if (scl_fall) begin
                        if (!sda_oe) begin
                            state <= eidp_pkg::S_IDLE;
                        end else if (load_tx) begin
                            sda_oe  <= !rd_byte[DW-1];
                            shreg   <= {rd_byte[DW-2:0], 1'b0};
                            bit_cnt <= eidp_pkg::BIT_FIRST;
                            state   <= eidp_pkg::S_TX;
                        end else begin
                            sda_oe  <= 1'b0;
                            bit_cnt <= eidp_pkg::BIT_ZERO;
                            state   <= eidp_pkg::S_RX;
                            if (byte_idx != eidp_pkg::IDX_DATA) begin
                                byte_idx <= byte_idx + 1'b1;
                            end
                        end
                    end
                end
                eidp_pkg::S_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt == eidp_pkg::BITS_PER_BYTE) begin
                            sda_oe <= 1'b0;
                            mack   <= 1'b0;
                            state  <= eidp_pkg::S_MACK;
                        end else begin
                            sda_oe  <= !shreg[DW-1];
                            shreg   <= {shreg[DW-2:0], 1'b0};
                            bit_cnt <= bit_cnt + 1'b1;
                        end
                    end
                end
                eidp_pkg::S_MACK: begin
                    if (scl_rise) begin
                        mack <= !sda_s;
                    end else if (scl_fall) begin
                        if (mack) begin
                            sda_oe  <= !rd_byte[DW-1];
                            shreg   <= {rd_byte[DW-2:0], 1'b0};
                            bit_cnt <= eidp_pkg::BIT_FIRST;
                            state   <= eidp_pkg::S_TX;
                        end else begin
                            state <= eidp_pkg::S_IDLE;
                        end
                    end
                end
                default: begin
                    state  <= eidp_pkg::S_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // address pointer
    // ****************************************
    always_ff @(posedge clk_link or posedge rst_link) begin
        if (rst_link) begin
            ptr      <= '0;
            lock_sel <= 1'b0;
        end else begin
            if (eval && byte_idx == eidp_pkg::IDX_ADDR_HI) begin
                lock_sel <= shreg[eidp_pkg::LOCK_ADDR_BIT];
            end
            if (eval && byte_idx == eidp_pkg::IDX_ADDR_LO) begin
                ptr <= addr_lo_offset;
            end else if (push_acc || load_tx) begin
                ptr <= next_offset(ptr);
            end
        end
    end

    // ****************************************
    // lock and commit control
    // ****************************************
    always_ff @(posedge clk_link or posedge rst_link) begin
        if (rst_link) begin
            pend_lock  <= 1'b0;
            pend_write <= 1'b0;
            locked     <= 1'b0;
            committing <= 1'b0;
            commit_tgl <= 1'b0;
        end else begin
            if (start_ev) begin
                pend_lock  <= 1'b0;
                pend_write <= 1'b0;
            end else if (stop_ev) begin
                pend_lock  <= 1'b0;
                pend_write <= 1'b0;
                if (pend_lock) begin
                    locked <= 1'b1;
                end
                committing <= pend_write;
            end else begin
                if (eval && byte_idx == eidp_pkg::IDX_DATA && lock_sel && !locked
                    && shreg[eidp_pkg::LOCK_DATA_BIT]) begin
                    pend_lock <= 1'b1;
                end
                if (push_acc) begin
                    pend_write <= 1'b1;
                end
                if (committing && !fifo_out_valid) begin
                    committing <= 1'b0;
                    commit_tgl <= !commit_tgl;
                end
            end
        end
    end

    // data bytes wait here until the stop; a full buffer refuses the byte with no ack
    eidp_fifo #(
        .WIDTH (eidp_pkg::FIFO_WIDTH),
        .DEPTH (eidp_pkg::FIFO_DEPTH)
    ) u_wbuf (
        .clk       (clk_link),
        .rst       (rst_link),
        .flush     (start_ev && !committing),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({ptr[IW-1:0], shreg}),
        .out_valid (fifo_out_valid),
        .out_ready (committing),
        .out_data  (fifo_out_data)
    );

    always_ff @(posedge clk_link or posedge rst_link) begin
        if (rst_link) begin
            for (int i = 0; i < eidp_pkg::PAGE_BYTES; i++) begin
                page[i] <= eidp_pkg::ERASED_BYTE;
            end
        end else if (committing && fifo_out_valid) begin
            page[fifo_out_data[eidp_pkg::FIFO_WIDTH-1:DW]] <= fifo_out_data[DW-1:0];
        end
    end

    // open drain: only ever pulls low
    always_ff @(posedge clk_link or posedge rst_link) begin
        if (rst_link) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // ****************************************
    // system clock status
    // ****************************************
    logic locked_meta, tgl_meta, tgl_s, tgl_q;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            locked_meta       <= 1'b0;
            id_page_locked    <= 1'b0;
            tgl_meta          <= 1'b0;
            tgl_s             <= 1'b0;
            tgl_q             <= 1'b0;
            id_page_committed <= 1'b0;
        end else begin
            locked_meta       <= locked;
            id_page_locked    <= locked_meta;
            tgl_meta          <= commit_tgl;
            tgl_s             <= tgl_meta;
            tgl_q             <= tgl_s;
            id_page_committed <= tgl_s ^ tgl_q;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb_link @(posedge clk_link); endclocking
    default disable iff (rst_link);

    property p_lock_sticky;
        locked |=> locked && !push_acc;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("page lock cleared or locked page written");

    property p_dev_type;
        state == eidp_pkg::S_ACK && sda_oe && byte_idx == eidp_pkg::IDX_DEV
            |-> dev_type == eidp_pkg::DEV_TYPE_ID;
    endproperty
    a_dev_type: assert property (p_dev_type)
        else $error("acked a foreign device type");

    property p_chip_sel;
        state == eidp_pkg::S_ACK && sda_oe && byte_idx == eidp_pkg::IDX_DEV
            |-> dev_cs == cs_s;
    endproperty
    a_chip_sel: assert property (p_chip_sel)
        else $error("acked with chip select mismatch");

    property p_read_dir;
        state == eidp_pkg::S_ACK && sda_oe && byte_idx == eidp_pkg::IDX_DEV && scl_fall
            |=> (state == eidp_pkg::S_TX) == $past(shreg[eidp_pkg::RW_BIT]);
    endproperty
    a_read_dir: assert property (p_read_dir)
        else $error("direction does not follow rw bit");

    property p_offset;
        eval && byte_idx == eidp_pkg::IDX_ADDR_LO |=> ptr == $past(addr_lo_offset);
    endproperty
    a_offset: assert property (p_offset)
        else $error("pointer not loaded from low offset bits");

    property p_query_ack;
        eval && byte_idx == eidp_pkg::IDX_DATA && !lock_sel && !locked && fifo_in_ready
            |=> state == eidp_pkg::S_ACK && sda_oe;
    endproperty
    a_query_ack: assert property (p_query_ack)
        else $error("unlocked page write byte not acked");

    property p_locked_nack;
        state == eidp_pkg::S_ACK && byte_idx == eidp_pkg::IDX_DATA && locked |-> !sda_oe;
    endproperty
    a_locked_nack: assert property (p_locked_nack)
        else $error("data byte acked while locked");

    property p_start_reset;
        start_ev && !committing
            |=> state == eidp_pkg::S_RX && !fifo_out_valid && !pend_lock && !pend_write;
    endproperty
    a_start_reset: assert property (p_start_reset)
        else $error("start left a pending command");

    property p_stop_idle;
        stop_ev && !pend_write && !pend_lock
            |=> state == eidp_pkg::S_IDLE && !committing ##1 !committing;
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("stop after query started programming");

    property p_lock_cmd;
        stop_ev && pend_lock |=> locked;
    endproperty
    a_lock_cmd: assert property (p_lock_cmd)
        else $error("lock command did not lock");

    property p_ptr_adv;
        state == eidp_pkg::S_MACK && scl_fall && mack
            |=> state == eidp_pkg::S_TX && ptr == next_offset($past(ptr));
    endproperty
    a_ptr_adv: assert property (p_ptr_adv)
        else $error("pointer did not advance on master ack");

    c_lock:    cover property (stop_ev && pend_lock);
    c_seq_rd:  cover property (state == eidp_pkg::S_MACK && scl_fall && mack);
    c_nack:    cover property (state == eidp_pkg::S_ACK && byte_idx == eidp_pkg::IDX_DATA
                               && locked);
    c_commit:  cover property (committing && fifo_out_valid);
endmodule

/* bench/eidp_master.sv */
`timescale 1ns/100ps
module eidp_master #(
    parameter int Q = 10
) (
    input  wire logic clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_low
);
    // ****************************************
    // bit-banged two-wire master
    // ****************************************
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // quarter bit of 40 ns keeps scl low well past the device's answer delay
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic start();
        sda_low = 1'b0;
        step(Q);
        scl = 1'b1;
        step(Q);
        sda_low = 1'b1;
        step(Q);
        scl = 1'b0;
        step(Q);
    endtask
    task automatic stop();
        sda_low = 1'b1;
        step(Q);
        scl = 1'b1;
        step(Q);
        sda_low = 1'b0;
        step(Q);
    endtask
    task automatic bit_io(input logic b, output logic s);
        sda_low = ~b;
        step(Q);
        scl = 1'b1;
        step(Q);
        s = sda_wire;
        step(Q);
        scl = 1'b0;
        step(Q);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(~mack, s);
    endtask
endmodule

/* bench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    // ****************************************
    // harness and scenarios
    // ****************************************
    logic       clk_sys  = 1'b0;
    logic       clk_link = 1'b0;
    logic       reset    = 1'b1;
    logic       scl, sda_low, sda_out, sda_oe, id_page_locked, id_page_committed;
    logic       sda_wire;
    logic [2:0] cs       = 3'h5;
    logic       a;
    logic       lk       = 1'b0;
    logic [7:0] d;
    logic [7:0] pm [32];
    int         mismatches = 0;
    int         checked    = 0;
    int         commits    = 0;
    always #2 clk_sys = ~clk_sys;
    initial #0.7 forever #3 clk_link = ~clk_link;
    // pull-up on the data wire
    assign sda_wire = ~(sda_low | (sda_oe & ~sda_out));
    always @(posedge clk_sys) if (id_page_committed === 1'b1) commits <= commits + 1;
    eidp_master m (.clk(clk_sys), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));
    eidp_top dut (.clk_sys(clk_sys), .reset(reset), .clk_link(clk_link), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .chip_select_bit_high(cs[2]), .chip_select_bit_mid(cs[1]),
        .chip_select_bit_low(cs[0]), .id_page_locked(id_page_locked),
        .id_page_committed(id_page_committed));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (mismatches == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic addr(input logic [7:0] hi, input logic [7:0] lo);
        m.start();
        m.wbyte({4'hb, cs, 1'b0}, a);
        check(a, 1'b1);
        m.wbyte(hi, a);
        m.wbyte(lo, a);
        check(a, 1'b1);
    endtask
    // upper offset bits set on purpose; reads stay inside the page
    task automatic rd(input logic [7:0] lo, input int n);
        addr(8'hfb, lo);
        m.start();
        m.wbyte({4'hb, cs, 1'b1}, a);
        check(a, 1'b1);
        for (int i = 0; i < n; i++) begin
            m.rbyte(i < n - 1, d);
            check(d, pm[lo[4:0] + 5'(i)]);
        end
        m.stop();
    endtask
    // the fifth byte overflows the 4-word buffer and must be refused
    task automatic wr(input logic [7:0] lo, input int n);
        int c0;
        c0 = commits;
        addr(8'hfb, lo);
        for (int i = 0; i < n; i++) begin
            m.wbyte(8'h30 + 8'(i), a);
            check(a, !lk && i < 4);
            if (!lk && i < 4) pm[lo[4:0] + 5'(i)] = 8'h30 + 8'(i);
        end
        m.stop();
        m.step(40);
        check(8'(commits - c0), !lk);
    endtask
    task automatic query();
        int c0;
        c0 = commits;
        addr(8'hfb, 8'hde);
        m.wbyte(8'h00, a);
        check(a, !lk);
        m.start();
        m.stop();
        m.step(40);
        check(8'(commits - c0), 8'h00);
        check(id_page_locked, lk);
    endtask
    task automatic reject();
        m.start();
        m.wbyte({4'ha, cs, 1'b0}, a);
        check(a, 1'b0);
        m.stop();
        m.start();
        m.wbyte({4'hb, ~cs, 1'b0}, a);
        check(a, 1'b0);
        m.stop();
    endtask
    task automatic lock_page();
        int k;
        addr(8'h04, 8'h00);
        m.wbyte(8'h02, a);
        check(a, 1'b1);
        m.stop();
        k = 0;
        while (id_page_locked !== 1'b1 && k < 100) begin
            m.step(1);
            k++;
        end
        if (k == 100) check(1'b0, 1'b1);
        lk = 1'b1;
    endtask
    initial begin
        foreach (pm[i]) pm[i] = 8'hff;
        repeat (10) @(posedge clk_sys);
        #1 reset = 1'b0;
        m.step(20);
        reject();
        rd(8'hca, 3);
        wr(8'hde, 5);
        rd(8'hde, 2);
        rd(8'hc0, 2);
        query();
        rd(8'hde, 1);
        lock_page();
        query();
        wr(8'hc0, 2);
        rd(8'hc0, 2);
        final_report();
    end
endmodule
